// file: verilog/sgps_defs.svh
`ifndef SGPS_DEFS_SVH
`define SGPS_DEFS_SVH

// Register byte offsets
`define SGPS_OFF_CTRL 8'h00
`define SGPS_OFF_TCLOSE 8'h04
`define SGPS_OFF_TOPEN 8'h08
`define SGPS_OFF_STATUS 8'h0C
`define SGPS_OFF_IRQ_STAT 8'h10
`define SGPS_OFF_IRQ_CLR 8'h14
`define SGPS_OFF_IRQ_EN 8'h18

// Control register fields
`define SGPS_CTRL_CLOSE 0
`define SGPS_CTRL_OPEN 1
`define SGPS_CTRL_ROUTE 2
`define SGPS_CTRL_WIRED_C 3
`define SGPS_CTRL_WIRED_O 4

// Status register fields
`define SGPS_ST_CLOSED 0
`define SGPS_ST_OPEN 1
`define SGPS_ST_TRANSIT 2
`define SGPS_ST_FAULT 3
`define SGPS_ST_CODE_LO 4
`define SGPS_ST_CLOSE_DRV 6
`define SGPS_ST_OPEN_DRV 7
`define SGPS_ST_AUX_C 8
`define SGPS_ST_AUX_O 9

// Interrupt event bits
`define SGPS_EV_CLOSED 0
`define SGPS_EV_OPENED 1
`define SGPS_EV_FAULT 2
`define SGPS_EV_W 3

// Reset values
`define SGPS_RST_ROUTE 1'h0
`define SGPS_RST_WIRED 1'h1
`define SGPS_RST_TMOVE_US 32'h000003E8

// Timing: moving times count in microsecond ticks
`define SGPS_CLK_PERIOD_NS 8
`define SGPS_TICK_NS 1000
`define SGPS_TICK_CYC ((`SGPS_TICK_NS + `SGPS_CLK_PERIOD_NS - 1) / `SGPS_CLK_PERIOD_NS)

`endif

// file: verilog/sgps_pkg.sv
package sgps_pkg;

    typedef enum logic [2:0] {
        SGPS_IDLE = 3'b001,
        SGPS_CLOSING = 3'b010,
        SGPS_OPENING = 3'b100
    } sgps_state_t;

    typedef enum logic [1:0] {
        SGPS_POS_MID = 2'h0,
        SGPS_POS_OPEN = 2'h1,
        SGPS_POS_CLOSED = 2'h2,
        SGPS_POS_DISTURB = 2'h3
    } sgps_code_t;

    typedef struct packed {
        logic closed;
        logic open;
        logic transit;
        logic fault;
        sgps_code_t code;
    } sgps_pos_t;

endpackage

// file: verilog/sgps_move_timer.sv
`timescale 1ns/1ns
module sgps_move_timer
    import sgps_pkg::*;
#(
    parameter int TIME_W = 24
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic tick, // Microsecond enable
    input wire logic load, // Start or restart
    input wire logic stop, // Abandon supervision
    input wire logic [TIME_W-1:0] load_val, // Moving time in ticks
    output logic running_q, // Timer counting
    output logic expired_q, // One-cycle pulse on expiry
    output logic [TIME_W-1:0] count_q // Ticks left
);

    initial begin
        if (TIME_W < 2 || TIME_W > 32) begin
            $error("sgps_move_timer: TIME_W out of range");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            running_q <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= 1'b0;
            if (load) begin
                // A zero setting still gives one tick of supervision
                count_q <= (load_val == '0) ? TIME_W'(1) : load_val;
                running_q <= 1'b1;
            end else if (stop) begin
                running_q <= 1'b0;
            end else if (running_q && tick) begin
                if (count_q == TIME_W'(1)) begin
                    count_q <= '0;
                    running_q <= 1'b0;
                    expired_q <= 1'b1;
                end else begin
                    count_q <= count_q - TIME_W'(1);
                end
            end
        end
    end

    chk_timer_reaches_zero: assert property (@(posedge pclk) disable iff (!presetn)
        running_q && tick && count_q == TIME_W'(1) && !load && !stop |=> expired_q && !running_q)
        else $error("timer did not expire at zero");

    chk_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
        load && load_val != '0 |=> running_q && count_q == $past(load_val))
        else $error("timer not restarted by load");

endmodule // sgps_move_timer

// file: verilog/sgps_supervisor.sv
// What this block does
// - Close and open moving times are separately configurable.
// - Close drive lasts at most the close time, ending early when closed.
// - Open drive lasts at most the open time, ending early when open.
// - Both feedback contacts are sampled every cycle, always.
// - Close command starts close timer; closed flag on feedback, else fault.
// - Open command starts open timer; open flag on feedback, else fault.
// - Position code: 0 intermediate, 1 open, 2 closed, 3 disturbed.
// - Contacts 1/0 give closed and code 2; 0/1 give open and code 1.
// - Equal contacts while a timer runs give transit only, code 0.
// - Equal contacts after timer elapsed give fault only, code 3.
// - With a single contact wired, command-to-feedback time is still supervised.
// - Protection close/open commands may be routed to the same drives.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "sgps_defs.svh"
module sgps_supervisor
    import sgps_pkg::*;
#(
    parameter int TIME_W = 24
) (
    input wire logic pclk, // System clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic aux_closed_pin, // Closed-position contact
    input wire logic aux_open_pin, // Open-position contact
    input wire logic prot_close, // Protection close request, same clock
    input wire logic prot_open, // Protection open request, same clock
    output logic close_drive, // Close coil drive
    output logic open_drive, // Open coil drive
    output sgps_pos_t position, // Position flags and code
    output logic irq // Level interrupt
);

    initial begin
        if (TIME_W < 2 || TIME_W > 32) begin
            $error("sgps_supervisor: TIME_W out of range");
        end
    end

    localparam int TICK_CYC = `SGPS_TICK_CYC;
    localparam int DIV_W = $clog2(TICK_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Contact synchronisers and tick divider

    logic [1:0] aux_c_sync_q;
    logic [1:0] aux_o_sync_q;
    logic [DIV_W-1:0] div_q;
    logic tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_c_sync_q <= 2'h0;
            aux_o_sync_q <= 2'h0;
        end else begin
            aux_c_sync_q <= {aux_c_sync_q[0], aux_closed_pin};
            aux_o_sync_q <= {aux_o_sync_q[0], aux_open_pin};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(TICK_CYC - 1)) begin
            div_q <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states; read data comes from a register

    logic route_q, wired_c_q, wired_o_q;
    logic [TIME_W-1:0] t_close_q, t_open_q;
    logic [`SGPS_EV_W-1:0] irq_stat_q, irq_en_q;
    logic [31:0] status_w;
    sgps_state_t st_q;

    wire setup = psel && !penable;
    wire wr_go = psel && penable && pready && pwrite;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `SGPS_OFF_CTRL) || (a == `SGPS_OFF_TCLOSE) || (a == `SGPS_OFF_TOPEN)
            || (a == `SGPS_OFF_STATUS) || (a == `SGPS_OFF_IRQ_STAT)
            || (a == `SGPS_OFF_IRQ_CLR) || (a == `SGPS_OFF_IRQ_EN);
    endfunction

    function automatic logic wr_at(input logic [7:0] off);
        wr_at = wr_go && paddr == off;
    endfunction

    always_comb begin
        status_w = 32'h00000000;
        status_w[`SGPS_ST_CLOSED] = position.closed;
        status_w[`SGPS_ST_OPEN] = position.open;
        status_w[`SGPS_ST_TRANSIT] = position.transit;
        status_w[`SGPS_ST_FAULT] = position.fault;
        status_w[`SGPS_ST_CODE_LO +: 2] = position.code;
        status_w[`SGPS_ST_CLOSE_DRV] = close_drive;
        status_w[`SGPS_ST_OPEN_DRV] = open_drive;
        status_w[`SGPS_ST_AUX_C] = aux_c_sync_q[1];
        status_w[`SGPS_ST_AUX_O] = aux_o_sync_q[1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    `SGPS_OFF_CTRL: prdata <= 32'({wired_o_q, wired_c_q, route_q, 2'h0});
                    `SGPS_OFF_TCLOSE: prdata <= 32'(t_close_q);
                    `SGPS_OFF_TOPEN: prdata <= 32'(t_open_q);
                    `SGPS_OFF_STATUS: prdata <= status_w;
                    `SGPS_OFF_IRQ_STAT: prdata <= 32'(irq_stat_q);
                    `SGPS_OFF_IRQ_EN: prdata <= 32'(irq_en_q);
                    default: prdata <= 32'h00000000;
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_q <= `SGPS_RST_ROUTE;
            wired_c_q <= `SGPS_RST_WIRED;
            wired_o_q <= `SGPS_RST_WIRED;
            t_close_q <= TIME_W'(`SGPS_RST_TMOVE_US);
            t_open_q <= TIME_W'(`SGPS_RST_TMOVE_US);
            irq_en_q <= '0;
        end else begin
            if (wr_at(`SGPS_OFF_CTRL)) begin
                route_q <= pwdata[`SGPS_CTRL_ROUTE];
                wired_c_q <= pwdata[`SGPS_CTRL_WIRED_C];
                wired_o_q <= pwdata[`SGPS_CTRL_WIRED_O];
            end
            if (wr_at(`SGPS_OFF_TCLOSE)) begin
                t_close_q <= pwdata[TIME_W-1:0];
            end
            if (wr_at(`SGPS_OFF_TOPEN)) begin
                t_open_q <= pwdata[TIME_W-1:0];
            end
            if (wr_at(`SGPS_OFF_IRQ_EN)) begin
                irq_en_q <= pwdata[`SGPS_EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commands, contact interpretation and timers

    wire sw_close = wr_at(`SGPS_OFF_CTRL) && pwdata[`SGPS_CTRL_CLOSE];
    wire sw_open = wr_at(`SGPS_OFF_CTRL) && pwdata[`SGPS_CTRL_OPEN];
    wire req_close = sw_close || (route_q && prot_close);
    wire req_open = sw_open || (route_q && prot_open);
    // Opening wins a clash: leaving a breaker open is the safe side
    wire cmd_open = req_open;
    wire cmd_close = req_close && !req_open;

    // An unwired contact is taken as the inverse of the wired one
    wire aux_c = wired_c_q ? aux_c_sync_q[1] : !aux_o_sync_q[1];
    wire aux_o = wired_o_q ? aux_o_sync_q[1] : !aux_c_sync_q[1];
    wire none_wired = !wired_c_q && !wired_o_q;
    wire at_closed = aux_c && !aux_o && !none_wired;
    wire at_open = aux_o && !aux_c && !none_wired;

    logic c_run, c_exp, o_run, o_exp;

    sgps_move_timer #(.TIME_W(TIME_W)) u_close_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .load(cmd_close),
        .stop(st_q != SGPS_CLOSING),
        .load_val(t_close_q),
        .running_q(c_run),
        .expired_q(c_exp),
        .count_q()
    );

    sgps_move_timer #(.TIME_W(TIME_W)) u_open_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .load(cmd_open),
        .stop(st_q != SGPS_OPENING),
        .load_val(t_open_q),
        .running_q(o_run),
        .expired_q(o_exp),
        .count_q()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Supervision state machine

    sgps_state_t st_d;
    logic fail_q;
    wire close_done = st_q == SGPS_CLOSING && at_closed;
    wire open_done = st_q == SGPS_OPENING && at_open;
    wire close_fail = st_q == SGPS_CLOSING && c_exp && !at_closed;
    wire open_fail = st_q == SGPS_OPENING && o_exp && !at_open;

    always_comb begin
        st_d = st_q;
        if (cmd_open) begin
            st_d = SGPS_OPENING;
        end else if (cmd_close) begin
            st_d = SGPS_CLOSING;
        end else begin
            case (st_q)
                SGPS_IDLE: st_d = SGPS_IDLE;
                SGPS_CLOSING: if (close_done || close_fail) st_d = SGPS_IDLE;
                SGPS_OPENING: if (open_done || open_fail) st_d = SGPS_IDLE;
                default: st_d = SGPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= SGPS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Expiry of the old command beats the clear of a new one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_q <= 1'b0;
        end else if (close_fail || open_fail) begin
            fail_q <= 1'b1;
        end else if (cmd_close || cmd_open) begin
            fail_q <= 1'b0;
        end
    end

    // Drives follow the next state, so they drop with feedback or expiry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            close_drive <= 1'b0;
            open_drive <= 1'b0;
        end else begin
            close_drive <= st_d == SGPS_CLOSING;
            open_drive <= st_d == SGPS_OPENING;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Position flags and code

    sgps_pos_t pos_d;

    always_comb begin
        pos_d = '{closed: 1'b0, open: 1'b0, transit: 1'b0, fault: 1'b0, code: SGPS_POS_MID};
        if (st_q != SGPS_IDLE) begin
            pos_d.transit = 1'b1;
            pos_d.code = SGPS_POS_MID;
        end else if (!fail_q && at_closed) begin
            pos_d.closed = 1'b1;
            pos_d.code = SGPS_POS_CLOSED;
        end else if (!fail_q && at_open) begin
            pos_d.open = 1'b1;
            pos_d.code = SGPS_POS_OPEN;
        end else begin
            pos_d.fault = 1'b1;
            pos_d.code = SGPS_POS_DISTURB;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position <= '{closed: 1'b0, open: 1'b0, transit: 1'b0, fault: 1'b0,
                code: SGPS_POS_MID};
        end else begin
            position <= pos_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, write-one-to-clear, set beats clear

    logic [`SGPS_EV_W-1:0] ev_w;
    logic [`SGPS_EV_W-1:0] clr_w;

    always_comb begin
        ev_w = '0;
        ev_w[`SGPS_EV_CLOSED] = close_done;
        ev_w[`SGPS_EV_OPENED] = open_done;
        ev_w[`SGPS_EV_FAULT] = close_fail || open_fail;
        clr_w = wr_at(`SGPS_OFF_IRQ_CLR) ? pwdata[`SGPS_EV_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
            irq <= |(((irq_stat_q & ~clr_w) | ev_w) & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // A command in the expiry cycle starts a new move, so transit is right then
    sequence s_close_fail;
        close_fail && !cmd_close && !cmd_open ##1 1'b1;
    endsequence

    chk_close_drive_end: assert property (@(posedge pclk) disable iff (!presetn)
        close_done && !cmd_close |=> !close_drive)
        else $error("close drive kept after closed feedback");

    chk_open_drive_end: assert property (@(posedge pclk) disable iff (!presetn)
        open_done && !cmd_open |=> !open_drive)
        else $error("open drive kept after open feedback");

    chk_drive_needs_timer: assert property (@(posedge pclk) disable iff (!presetn)
        close_drive |-> c_run || c_exp)
        else $error("close drive without running close timer");

    chk_close_fault_code: assert property (@(posedge pclk) disable iff (!presetn)
        s_close_fail |=> position.code == SGPS_POS_DISTURB && position.fault
            && !position.transit)
        else $error("expired close not reported as disturbed");

    chk_transit_code: assert property (@(posedge pclk) disable iff (!presetn)
        st_q != SGPS_IDLE |=> position.transit && position.code == SGPS_POS_MID
            && !position.fault && !position.closed && !position.open)
        else $error("transit not reported while moving");

    chk_closed_code: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SGPS_IDLE && !fail_q && wired_c_q && wired_o_q && aux_c_sync_q[1]
            && !aux_o_sync_q[1] |=> position.closed && position.code == SGPS_POS_CLOSED
            && !position.open)
        else $error("closed contacts not reported as closed");

    chk_open_code: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SGPS_IDLE && !fail_q && wired_c_q && wired_o_q && !aux_c_sync_q[1]
            && aux_o_sync_q[1] |=> position.open && position.code == SGPS_POS_OPEN
            && !position.closed)
        else $error("open contacts not reported as open");

    chk_command_restart: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_close && !close_fail && !open_fail |=> st_q == SGPS_CLOSING && c_run && !fail_q)
        else $error("close command did not restart supervision");

    chk_open_restart: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_open |=> st_q == SGPS_OPENING && o_run ##1 open_drive || st_q != SGPS_OPENING)
        else $error("open command did not start open supervision");

    chk_contact_sample: assert property (@(posedge pclk) disable iff (!presetn)
        aux_c_sync_q[1] == $past(aux_closed_pin, 2) || $past(!presetn, 2))
        else $error("closed contact not sampled every cycle");

endmodule // sgps_supervisor

// file: verification/sgps_gear_model.sv
`timescale 1ns/1ns
module sgps_gear_model (
    input wire logic pclk, // System clock
    input wire logic close_drive, // Close coil
    input wire logic open_drive, // Open coil
    input wire logic [15:0] move_cyc, // Travel time in cycles
    input wire logic stuck, // Leaves end position but never arrives
    input wire logic wired_o, // Open contact connected
    output logic aux_closed_pin, // Closed-position contact
    output logic aux_open_pin // Open-position contact
);
    logic [1:0] pos_q = 2'h1; // 0 travelling, 1 open, 2 closed
    logic [15:0] run_q = 16'h0000;
    logic toggle_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        toggle_q <= ~toggle_q;
        if ((close_drive | open_drive) === 1'b1) begin
            run_q <= run_q + 16'h0001;
            if (run_q == 16'h0001) begin
                pos_q <= 2'h0;
            end
            if (run_q == move_cyc && !stuck) begin
                pos_q <= close_drive ? 2'h2 : 2'h1;
            end
        end else begin
            run_q <= 16'h0000;
        end
    end

    // Closed contact is always wired so at least one feedback exists
    assign aux_closed_pin = (pos_q == 2'h2);
    // An unconnected input floats: a changing pattern, never a steady level
    assign aux_open_pin = wired_o ? (pos_q == 2'h1) : toggle_q;
endmodule // sgps_gear_model

// file: verification/sgps_supervisor_test.sv
`timescale 1ns/1ns
`include "sgps_defs.svh"
`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module sgps_supervisor_test import sgps_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic aux_c;
    logic aux_o;
    logic prot_close = 1'b0;
    logic prot_open = 1'b0;
    logic close_drive;
    logic open_drive;
    sgps_pos_t position;
    logic irq;
    logic stuck = 1'b0;
    logic wired_o = 1'b1;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    always #4 pclk = ~pclk;

    sgps_supervisor #(.TIME_W(24)) u_sgps_supervisor (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_closed_pin(aux_c),
        .aux_open_pin(aux_o), .prot_close(prot_close), .prot_open(prot_open),
        .close_drive(close_drive), .open_drive(open_drive), .position(position), .irq(irq));

    sgps_gear_model u_sgps_gear_model (.pclk(pclk), .close_drive(close_drive),
        .open_drive(open_drive), .move_cyc(16'h0032), .stuck(stuck), .wired_o(wired_o),
        .aux_closed_pin(aux_c), .aux_open_pin(aux_o));

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bound is far above the fewer than a thousand cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            final_report();
        end
    end

    // Only the bench timeout ends a wait for pready
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, exp, r)
    endtask

    // Drive length counts from about the command edge; lo/hi allow the slack
    task automatic watch(input logic [5:0] exp_pos, input int lo, input int hi);
        int n;
        n = 10;
        repeat (10) @(posedge pclk);
        `CHK("transit", 6'h08, position)
        while ((close_drive | open_drive) === 1'b1 && n < 1000) begin
            n++;
            @(posedge pclk);
        end
        `CHK("drive_len", 1'b1, (n >= lo && n <= hi))
        repeat (4) @(posedge pclk);
        `CHK("position", exp_pos, position)
    endtask

    task automatic irq_seen(input logic [31:0] stat);
        rdc(`SGPS_OFF_IRQ_STAT, stat, "irq_stat");
        `CHK("irq_high", 1'b1, irq)
        wr(`SGPS_OFF_IRQ_CLR, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq_low", 1'b0, irq)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK("idle_open", 6'h11, position)
        rdc(`SGPS_OFF_CTRL, 32'h18, "ctrl_rst");
        rdc(`SGPS_OFF_TCLOSE, `SGPS_RST_TMOVE_US, "tclose_rst");
        rdc(`SGPS_OFF_TOPEN, `SGPS_RST_TMOVE_US, "topen_rst");
        rdc(`SGPS_OFF_IRQ_EN, 32'h0, "irq_en_rst");
        rdc(`SGPS_OFF_IRQ_STAT, 32'h0, "irq_stat_rst");
        apb(1'b0, 8'h1C, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        // Short moving times keep the run brief: 3 us is 375 cycles
        wr(`SGPS_OFF_TCLOSE, 32'h3);
        wr(`SGPS_OFF_TOPEN, 32'h4);
        rdc(`SGPS_OFF_TOPEN, 32'h4, "topen");
        wr(`SGPS_OFF_TOPEN, 32'h3);
        wr(`SGPS_OFF_IRQ_EN, 32'h7);
        $display("test reset done");

        wr(`SGPS_OFF_CTRL, 32'h19);
        watch(6'h22, 40, 80);
        rdc(`SGPS_OFF_STATUS, 32'h121, "status_closed");
        irq_seen(32'h1);
        wr(`SGPS_OFF_CTRL, 32'h1A);
        watch(6'h11, 40, 80);
        rdc(`SGPS_OFF_STATUS, 32'h212, "status_open");
        irq_seen(32'h2);
        $display("test moves done");

        stuck <= 1'b1;
        wr(`SGPS_OFF_CTRL, 32'h19);
        watch(6'h07, 245, 382);
        rdc(`SGPS_OFF_IRQ_STAT, 32'h4, "fault_stat");
        wr(`SGPS_OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("irq_masked", 1'b0, irq)
        wr(`SGPS_OFF_IRQ_CLR, 32'h7);
        wr(`SGPS_OFF_IRQ_EN, 32'h7);
        stuck <= 1'b0;
        wr(`SGPS_OFF_CTRL, 32'h1A);
        watch(6'h11, 40, 80);
        wr(`SGPS_OFF_IRQ_CLR, 32'h7);
        $display("test fault done");

        prot_close <= 1'b1;
        @(posedge pclk);
        prot_close <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("unrouted", 1'b0, close_drive)
        wr(`SGPS_OFF_CTRL, 32'h1C);
        prot_close <= 1'b1;
        @(posedge pclk);
        prot_close <= 1'b0;
        watch(6'h22, 40, 80);
        prot_open <= 1'b1;
        @(posedge pclk);
        prot_open <= 1'b0;
        watch(6'h11, 40, 80);
        $display("test protection done");

        wired_o <= 1'b0;
        wr(`SGPS_OFF_CTRL, 32'h08);
        wr(`SGPS_OFF_CTRL, 32'h09);
        watch(6'h22, 40, 80);
        wr(`SGPS_OFF_CTRL, 32'h00);
        repeat (4) @(posedge pclk);
        `CHK("none_wired", 6'h07, position)
        $display("test single contact done");
        final_report();
    end
endmodule // sgps_supervisor_test
